// >>> rtl/msx_pkg.sv
// Purpose: Shared constants for the master-only serial exchange block
// Assumes: 32-bit Avalon-MM register slave, 50 MHz system clock
// Notes: Offsets are byte addresses
package msx_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] MSX_OFF_DATA = 4'h0;
    localparam logic [3:0] MSX_OFF_CTRL = 4'h4;
    localparam logic [3:0] MSX_OFF_MASK = 4'h8;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int MSX_RATE_HI = 15;
    localparam int MSX_RATE_LO = 13;
    localparam int MSX_ENABLE_BIT = 9;
    localparam int MSX_XCH_BIT = 8;
    localparam int MSX_IRQ_BIT = 7;
    localparam int MSX_IRQEN_BIT = 6;
    localparam int MSX_PHA_BIT = 5;
    localparam int MSX_POL_BIT = 4;
    localparam int MSX_CNT_HI = 3;
    localparam int MSX_CNT_LO = 0;
    localparam logic [15:0] MSX_CTRL_RESET = 16'h0000;
    localparam logic [15:0] MSX_DATA_RESET = 16'h0000;
    localparam logic [31:0] MSX_UNMAPPED = 32'h00000000;
    // ------------------------------------------------------------
    // Timing: least divide is 4, half period of 2 system clocks
    // ------------------------------------------------------------
    localparam int MSX_MIN_DIV = 4;
    localparam logic [7:0] MSX_MIN_HALF = 8'(MSX_MIN_DIV / 2);
    localparam int MSX_WORD_W = 16;
    typedef enum logic [1:0] {MSX_IDLE, MSX_LEAD, MSX_TRAIL} msx_state_e;
endpackage

// >>> rtl/msx_rate_div.sv
// Purpose: Half-period tick generator for the serial clock
// Assumes: rate code 0..7, divide 4 << code
// Notes: Held cleared while not running
`timescale 1ns/1ps
`default_nettype none
module msx_rate_div (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [2:0] rateCode,
    // Tick
    output logic halfTick
);
    import msx_pkg::*;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] halfLen;

    // Half period length and counter next value
    always_comb begin
        halfLen = 8'(MSX_MIN_HALF << rateCode); // RL15
        next_count = count;
        if (!run) begin
            next_count = 8'h00; // RL19
        end else if (count == 8'(halfLen - 8'h01)) begin
            next_count = 8'h00;
        end else begin
            next_count = 8'(count + 8'h01);
        end
        halfTick = run && (count == 8'(halfLen - 8'h01));
    end

    // Counter register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/msx_shifter.sv
// Purpose: Shift register for one exchange, MSB first
// Assumes: bit length len = count field + 1
// Notes: Shift and capture strobes come from the sequencer
`timescale 1ns/1ps
`default_nettype none
module msx_shifter #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadData,
    input wire logic [3:0] topBit,
    input wire logic capture,
    input wire logic shift,
    input wire logic rxBit,
    // Data
    output logic [WIDTH-1:0] word,
    output logic txBit
);
    import msx_pkg::*;
    logic [WIDTH-1:0] next_word;
    logic sampled;
    logic next_sampled;

    // Capture latches rx, shift moves it in at the bottom
    // A capture in the shift cycle (phase 1) passes rx straight in
    always_comb begin
        next_word = word;
        next_sampled = sampled;
        if (load) begin
            next_word = loadData;
        end else if (shift) begin
            next_word = {word[WIDTH-2:0], capture ? rxBit : sampled}; // RL17
        end
        if (capture) begin
            next_sampled = rxBit;
        end
        txBit = word[topBit]; // RL17
    end

    // Shift register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            word <= MSX_DATA_RESET;
            sampled <= 1'b0;
        end else begin
            word <= next_word;
            sampled <= next_sampled;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/msx_exchange.sv
// Purpose: Master-only serial exchange unit with Avalon-MM registers
// Assumes: pins are synchronous to sys_clk; chip enable is outside
// Notes: One exchange of 1..16 bits per trigger
// Operation
// RL1: Unit is master only, makes clock
// RL2: Software selects serial pin function first
// RL3: Set enable alone, then other fields
// RL4: Data writes ignored disabled or busy
// RL5: Trigger bit stays set until done
// RL6: Done raises interrupt, gated by mask
// RL7: Done flag cleared by writing zero
// RL8: Enable stays across back-to-back exchanges
// RL9: Phase 0: out on fall, in rise
// RL10: Phase 0: MSB out at data write
// RL11: Phase 1: out on rise, in fall
// RL12: Phase 1: MSB out first rise
// RL13: Polarity inverts pin clock only
// RL14: Chip enable comes from general pin
// RL15: Rate field divides clock 4 to 512
// RL16: Idle clock level equals polarity
// RL17: MSB first, received data right-aligned
// RL18: Data read during exchange is undefined
// RL19: Disabled: divider, shifter stopped, clock idle
// RL20: Exactly bit count clock pulses issued
`timescale 1ns/1ps
`default_nettype none
module msx_exchange (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Serial pins
    output logic serial_clock_out,
    output logic serial_data_out,
    input wire logic serial_data_in,
    // Interrupt request to the processor
    output logic exchangeIrq
);
    import msx_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic serial_irq_mask_bit;
    logic next_serial_irq_mask_bit;
    msx_state_e state;
    msx_state_e next_state;
    logic [4:0] pulses;
    logic [4:0] next_pulses;
    logic [31:0] next_readdata;
    logic rdValid;
    logic next_rdValid;
    logic txHold;
    logic next_txHold;
    logic serialClk;
    logic next_serialClk;
    logic halfTick;
    logic load;
    logic capture;
    logic shift;
    logic [15:0] word;
    logic txBit;
    logic enable;
    logic busy;
    logic phase;
    logic [3:0] topBit;
    logic wrCtrl;
    logic wrData;
    logic wrMask;
    logic done;

    assign enable = ctrl[MSX_ENABLE_BIT];
    assign busy = ctrl[MSX_XCH_BIT];
    assign phase = ctrl[MSX_PHA_BIT];
    assign topBit = ctrl[MSX_CNT_HI:MSX_CNT_LO];

    // ------------------------------------------------------------
    // Bus decode: writes answer at once, reads after one wait
    // ------------------------------------------------------------
    // Reads wait one cycle so the answer comes from a flip-flop
    assign waitrequest = read && !rdValid;
    assign wrCtrl = write && (address == MSX_OFF_CTRL) && (byteenable[1:0] == 2'b11);
    assign wrData = write && (address == MSX_OFF_DATA) && (byteenable[1:0] == 2'b11);
    assign wrMask = write && (address == MSX_OFF_MASK) && byteenable[0];
    // Data load only when enabled and idle
    assign load = wrData && enable && !busy; // RL4

    // Read data mux, loaded in the wait cycle of a read
    always_comb begin
        next_readdata = readdata;
        next_rdValid = read && !rdValid;
        if (read && !rdValid) begin
            if (address == MSX_OFF_DATA) begin
                next_readdata = {16'h0000, word}; // RL18
            end else if (address == MSX_OFF_CTRL) begin
                next_readdata = {16'h0000, ctrl};
            end else if (address == MSX_OFF_MASK) begin
                next_readdata = {31'h00000000, serial_irq_mask_bit};
            end else begin
                next_readdata = MSX_UNMAPPED;
            end
        end
    end

    // ------------------------------------------------------------
    // Divider and shifter
    // ------------------------------------------------------------
    msx_rate_div u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(enable && (state != MSX_IDLE)), // RL19
        .rateCode(ctrl[MSX_RATE_HI:MSX_RATE_LO]),
        .halfTick(halfTick)
    );

    msx_shifter #(.WIDTH(MSX_WORD_W)) u_shift (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(load),
        .loadData(writedata[15:0]),
        .topBit(topBit),
        .capture(capture),
        .shift(shift),
        .rxBit(serial_data_in),
        .word(word),
        .txBit(txBit)
    );

    // ------------------------------------------------------------
    // Exchange sequencer
    // ------------------------------------------------------------
    // Lead edge is the rising logical edge, trail the falling
    always_comb begin
        next_state = state;
        next_pulses = pulses;
        next_serialClk = serialClk;
        next_txHold = txHold;
        capture = 1'b0;
        shift = 1'b0;
        done = 1'b0;
        if (load && !phase) begin
            next_txHold = writedata[topBit]; // RL10
        end
        case (state)
            MSX_IDLE: begin
                next_serialClk = 1'b0;
                if (busy && enable) begin
                    next_state = MSX_LEAD; // RL1
                    next_pulses = 5'({1'b0, topBit} + 5'h01);
                    if (!phase) begin
                        next_txHold = txBit;
                    end
                end
            end
            MSX_LEAD: begin
                if (halfTick) begin
                    next_serialClk = 1'b1;
                    next_state = MSX_TRAIL;
                    if (phase) begin
                        next_txHold = txBit; // RL11 RL12
                        capture = 1'b0;
                    end else begin
                        capture = 1'b1; // RL9
                    end
                end
            end
            MSX_TRAIL: begin
                if (halfTick) begin
                    next_serialClk = 1'b0;
                    next_pulses = 5'(pulses - 5'h01);
                    if (phase) begin
                        capture = 1'b1; // RL11
                    end
                    shift = 1'b1;
                    if (pulses == 5'h01) begin
                        next_state = MSX_IDLE; // RL20
                        done = 1'b1;
                    end else begin
                        next_state = MSX_LEAD;
                    end
                end
            end
            default: begin
                next_state = MSX_IDLE;
            end
        endcase
        // A disable mid-exchange parks the sequencer at once
        if (!enable) begin
            next_state = MSX_IDLE; // RL19
            next_serialClk = 1'b0;
        end
    end

    // Phase 0 output follows the shifted word after each fall but the last; idle shows txHold
    logic txOut;
    assign txOut = (phase || state == MSX_IDLE) ? txHold : txBit; // RL9

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_serial_irq_mask_bit = serial_irq_mask_bit;
        if (wrMask) begin
            next_serial_irq_mask_bit = writedata[0];
        end
        if (wrCtrl) begin
            next_ctrl = writedata[15:0] & 16'he3ff;
            // Trigger only sets, hardware clears it
            next_ctrl[MSX_XCH_BIT] = ctrl[MSX_XCH_BIT] || (writedata[MSX_XCH_BIT] && enable); // RL3 RL5
            // Done flag cleared by zero, kept by one
            next_ctrl[MSX_IRQ_BIT] = ctrl[MSX_IRQ_BIT] && writedata[MSX_IRQ_BIT]; // RL7
            if (busy) begin
                next_ctrl[MSX_RATE_HI:MSX_POL_BIT] = {ctrl[MSX_RATE_HI:MSX_RATE_LO], 3'h0,
                    writedata[MSX_ENABLE_BIT], next_ctrl[MSX_XCH_BIT], next_ctrl[MSX_IRQ_BIT],
                    ctrl[MSX_IRQEN_BIT], ctrl[MSX_PHA_BIT], ctrl[MSX_POL_BIT]};
                next_ctrl[MSX_CNT_HI:MSX_CNT_LO] = ctrl[MSX_CNT_HI:MSX_CNT_LO];
            end
        end
        if (done) begin
            next_ctrl[MSX_XCH_BIT] = 1'b0; // RL5 RL8
            next_ctrl[MSX_IRQ_BIT] = 1'b1; // RL6
        end
        if (!next_ctrl[MSX_ENABLE_BIT]) begin
            next_ctrl[MSX_XCH_BIT] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= MSX_CTRL_RESET;
            serial_irq_mask_bit <= 1'b1;
            state <= MSX_IDLE;
            pulses <= 5'h00;
            serialClk <= 1'b0;
            txHold <= 1'b0;
            readdata <= 32'h00000000;
            rdValid <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            serial_irq_mask_bit <= next_serial_irq_mask_bit;
            state <= next_state;
            pulses <= next_pulses;
            serialClk <= next_serialClk;
            txHold <= next_txHold;
            readdata <= next_readdata;
            rdValid <= next_rdValid;
        end
    end

    // Pin drive: polarity only inverts the clock pin
    assign serial_clock_out = serialClk ^ ctrl[MSX_POL_BIT]; // RL13 RL16
    assign serial_data_out = txOut;
    assign exchangeIrq = ctrl[MSX_IRQ_BIT] && ctrl[MSX_IRQEN_BIT] && !serial_irq_mask_bit; // RL6

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_IDLE_CLK: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL16
        (state == MSX_IDLE) |-> (serial_clock_out == ctrl[MSX_POL_BIT]))
        else $error("clock not at idle level");
    AST_DISABLED_STOP: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL19
        !enable |=> (state == MSX_IDLE))
        else $error("sequencer runs while disabled");
    AST_DATA_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL4
        (wrData && busy && !shift) |=> (word == $past(word)))
        else $error("data written while busy");
    AST_XCH_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
        (busy && enable && !done) |=> busy)
        else $error("trigger dropped early");
    AST_DONE_SETS_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
        done |=> (ctrl[MSX_IRQ_BIT] && !busy))
        else $error("done flag not raised");
    AST_IRQ_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
        (wrCtrl && !writedata[MSX_IRQ_BIT] && !done) |=> !ctrl[MSX_IRQ_BIT])
        else $error("done flag not cleared");
    AST_PHA0_MSB: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL10
        (load && !phase) |=> (serial_data_out == $past(writedata[topBit])))
        else $error("msb not shown at load");
    AST_LAST_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL20
        (state == MSX_TRAIL && halfTick && pulses == 5'h01 && enable) |=> (state == MSX_IDLE))
        else $error("extra clock pulse");

    // ------------------------------------------------------------
    // Data line assertions per phase
    // ------------------------------------------------------------
    // Phase 0 holds the line through the rise, phase 1 through the fall
    AST_PHA0_HOLD_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
        (state == MSX_LEAD && !phase && enable && !wrCtrl) |=> $stable(serial_data_out))
        else $error("phase 0 data moved at rise");
    AST_PHA1_HOLD_FALL: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL11
        (state == MSX_TRAIL && phase && enable && !wrCtrl) |=> $stable(serial_data_out))
        else $error("phase 1 data moved at fall");
    // Phase 1 launches each bit at the rise
    AST_PHA1_LAUNCH: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
        (state == MSX_LEAD && halfTick && phase && !wrCtrl) |=> (serial_data_out == $past(txBit)))
        else $error("phase 1 bit not launched at rise");
    // Last phase 1 bit is captured and shifted in one edge
    AST_RX_LAST_BIT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL17
        (state == MSX_TRAIL && halfTick && phase && pulses == 5'h01 && enable)
        |=> (word[0] == $past(serial_data_in)))
        else $error("last received bit lost");

    // ------------------------------------------------------------
    // Control and status assertions
    // ------------------------------------------------------------
    // A trigger needs enable and starts the sequencer at once
    AST_TRIGGER_NEEDS_ENABLE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
        !enable |=> !busy)
        else $error("trigger set while disabled");
    AST_TRIGGER_STARTS: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
        (state == MSX_IDLE && busy && enable) |=> (state == MSX_LEAD))
        else $error("trigger did not start exchange");
    // Data loads only while the sequencer rests
    AST_LOAD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL4
        load |-> (state == MSX_IDLE))
        else $error("data loaded during exchange");
    // Enable survives the end of an exchange
    AST_ENABLE_KEPT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
        (done && enable && !wrCtrl) |=> enable)
        else $error("enable dropped at done");
    // Masked request never reaches the processor
    AST_IRQ_MASKED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
        serial_irq_mask_bit |-> !exchangeIrq)
        else $error("masked request raised");
    // Done flag stays until software writes zero
    AST_IRQ_HELD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
        (ctrl[MSX_IRQ_BIT] && !(wrCtrl && !writedata[MSX_IRQ_BIT])) |=> ctrl[MSX_IRQ_BIT])
        else $error("done flag dropped");
    // Disabled unit parks the clock pin at once
    AST_DISABLED_PIN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL19
        !enable |=> (serial_clock_out == ctrl[MSX_POL_BIT]))
        else $error("clock pin moved while disabled");
endmodule
`default_nettype wire

// >>> bench/msx_slave_model.sv
// Purpose: Serial slave stand-in facing the exchange unit
// Assumes: bench raises sel around each exchange, like a general pin
// Notes: A deselected data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module msx_slave_model (
    // Serial pins
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Set-up from bench
    input wire logic sel,
    input wire logic clock_polarity_select,
    input wire logic clock_phase_select,
    input wire logic [3:0] topBit,
    input wire logic [15:0] txWord,
    output logic [15:0] rxWord
);
    logic lc;
    logic drv = 1'b0;
    int idx;
    // Logical clock with polarity removed
    assign lc = sclk ^ clock_polarity_select;
    assign miso = sel ? drv : ~drv;
    // First bit waits on the line in phase 0 only
    always @(posedge sel) begin
        idx = topBit;
        drv = clock_phase_select ? ~txWord[topBit] : txWord[topBit];
        rxWord = 16'h0000;
    end
    // Rising logical edge
    always @(posedge lc) begin
        if (sel && clock_phase_select) begin
            drv = txWord[idx];
            idx = idx - 1;
        end else if (sel) begin
            rxWord = {rxWord[14:0], mosi};
        end
    end
    // Falling logical edge
    always @(negedge lc) begin
        if (sel && clock_phase_select) begin
            rxWord = {rxWord[14:0], mosi};
        end else if (sel && idx > 0) begin
            idx = idx - 1;
            drv = txWord[idx];
        end
    end
endmodule
`default_nettype wire

// >>> bench/test_master_only_spi_exchange.sv
// Purpose: Self-checking bench for the serial exchange unit
// Assumes: waitrequest answers, readdata taken at the accept edge
// Notes: Random words and rates from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module test_master_only_spi_exchange;
    import msx_pkg::*;
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic sclk;
    logic mosi;
    logic miso;
    logic irq;
    logic sel = 1'b0;
    logic clock_polarity_select = 1'b0;
    logic clock_phase_select = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [2:0] rate = 3'h0;
    logic [15:0] slaveTx = 16'h0;
    logic [15:0] slaveRx;
    logic [15:0] tx;
    logic [31:0] rd;
    logic prevClk = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int gap = 0;
    int lastGap = 0;
    int toggles = 0;
    int t0 = 0;
    int seed = 32'had5bb23b;
    // ------------------------------------------------------------
    // Design, slave and clock
    // ------------------------------------------------------------
    msx_exchange u_msx_exchange (.sys_clk(clk), .rst_n(rstN), .address(address), .read(read),
        .write(write), .byteenable(4'hf), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .serial_clock_out(sclk), .serial_data_out(mosi),
        .serial_data_in(miso), .exchangeIrq(irq));
    msx_slave_model u_msx_slave_model (.sclk(sclk), .mosi(mosi), .miso(miso), .sel(sel), .clock_polarity_select(clock_polarity_select),
        .clock_phase_select(clock_phase_select), .topBit(cnt), .txWord(slaveTx), .rxWord(slaveRx));
    always #10 clk = ~clk;
    // Pin clock edge counter, half period meter and timeout
    always @(posedge clk) begin
        cycles <= cycles + 1;
        prevClk <= sclk;
        gap <= (sclk != prevClk) ? 1 : gap + 1;
        if (sclk != prevClk) begin
            toggles <= toggles + 1;
            lastGap <= gap;
        end
        if (cycles == 60000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Tasks and expectation functions
    // ------------------------------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        if (!wr) rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, 32'h0);
        check(rd, exp, msg);
    endtask
    function automatic logic [15:0] msk(input logic [3:0] n);
        return 16'((17'h1 << (n + 1)) - 1);
    endfunction
    function automatic logic [31:0] ctrl(input logic exchange_trigger);
        return {16'h0, rate, 3'b000, 1'b1, exchange_trigger, 1'b0, 1'b1, clock_phase_select, clock_polarity_select, cnt};
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rstN <= 1'b1;
        rdchk(MSX_OFF_CTRL, {16'h0, MSX_CTRL_RESET}, "ctrl reset");
        rdchk(MSX_OFF_MASK, 32'h1, "mask reset");
        rdchk(4'hc, MSX_UNMAPPED, "unmapped");
        check(sclk, 1'b0, "idle clock at reset");
        bus(1'b1, MSX_OFF_DATA, 32'h1234);
        rdchk(MSX_OFF_DATA, 32'h0, "data write while disabled");
        bus(1'b1, MSX_OFF_CTRL, 32'h0200);
        // Every phase and polarity, enable left set throughout
        for (int i = 0; i < 12; i++) begin
            clock_phase_select = i[0];
            clock_polarity_select = i[1];
            rate = (i == 11) ? 3'h7 : 3'($random(seed) & 3);
            cnt = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($random(seed));
            tx = 16'($random(seed));
            slaveTx = 16'($random(seed));
            bus(1'b1, MSX_OFF_MASK, {31'h0, i[2]});
            bus(1'b1, MSX_OFF_CTRL, ctrl(1'b0));
            bus(1'b1, MSX_OFF_DATA, {16'h0, tx});
            @(negedge clk);
            if (!clock_phase_select) check(mosi, tx[cnt], "first bit at load");
            check(sclk, clock_polarity_select, "idle level");
            sel <= 1'b1;
            t0 = toggles;
            bus(1'b1, MSX_OFF_CTRL, ctrl(1'b1));
            rd = '1;
            if (cnt > 3) begin
                bus(1'b1, MSX_OFF_DATA, {16'h0, ~tx});
                rdchk(MSX_OFF_CTRL, ctrl(1'b1), "busy");
            end
            for (int k = 0; k < 3000 && rd[MSX_XCH_BIT] !== 1'b0; k++) bus(1'b0, MSX_OFF_CTRL, 32'h0);
            sel <= 1'b0;
            check(rd[MSX_IRQ_BIT], 1'b1, "done flag");
            check(irq, !i[2], "irq gated by mask");
            check(toggles - t0, 2 * (cnt + 1), "pulse count");
            check(lastGap, 2 << rate, "half period");
            check(sclk, clock_polarity_select, "idle after exchange");
            check(slaveRx, tx & msk(cnt), "word sent");
            // Unsent tx bits move up as the received bits enter at the bottom
            rdchk(MSX_OFF_DATA, {16'h0, 16'(tx << (cnt + 1)) | (slaveTx & msk(cnt))}, "word received");
            bus(1'b1, MSX_OFF_CTRL, ctrl(1'b0));
            @(negedge clk);
            check(irq, 1'b0, "irq cleared");
        end
        // Disabled unit ignores a trigger and keeps its clock still
        bus(1'b1, MSX_OFF_CTRL, 32'h0000);
        bus(1'b1, MSX_OFF_CTRL, 32'h0100);
        t0 = toggles;
        repeat (40) @(posedge clk);
        check(toggles - t0, 0, "clock while disabled");
        rdchk(MSX_OFF_CTRL, 32'h0, "trigger while disabled");
        close_out();
    end
endmodule
`default_nettype wire
